// ==== src/swcc_defines.svh ====
/*
 * register offsets, field positions, reset values and nanosecond timings of the
 * sleep and wake-up clock control block.
 * assumes a single 10 MHz system clock and byte addresses on an 8-bit bus.
 */
`ifndef SWCC_DEFINES_SVH
`define SWCC_DEFINES_SVH

// register byte offsets
`define SWCC_SCLK_OFS 8'h00
`define SWCC_OSC_OFS 8'h04
`define SWCC_FLAG_OFS 8'h08
`define SWCC_MASK_OFS 8'h0c
`define SWCC_STAT_OFS 8'h10

// system_clock_control_reg fields
`define SWCC_SRC_POS 0
`define SWCC_DIV_POS 4
`define SWCC_WSRC_POS 8
`define SWCC_WDIV_POS 12
`define SWCC_WMODE_POS 15
`define SWCC_SCLK_BITS 16'hb333
`define SWCC_SCLK_RESET 16'h0000

// oscillator_control_reg fields: enables in [3:0], keep-in-sleep in [11:8]
`define SWCC_EN_POS 0
`define SWCC_KEEP_POS 8
`define SWCC_OSC_BITS 12'hf0f
`define SWCC_OSC_RESET 12'h001
`define SWCC_LOW_SPEED_ONLY 4'h2

// interrupt flag bits
`define SWCC_FLAG_MODE_DONE 0
`define SWCC_FLAG_WAKE 1

// timing
`define SWCC_CLK_PERIOD_NS 100
`define SWCC_ECO_DELAY_NS 1000000

`endif

// ==== src/swcc_delay_timer.sv ====
/*
 * delay timer: counts while run is high and pulses done once the count
 * is reached; dropping run clears it.
 * assumes one synchronous active-low reset and cycles below 16384.
 */
`timescale 1ns/100ps
module swcc_delay_timer #(
   parameter int CYCLES = 10000
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   output logic done
);

   logic [13:0] count;

   // restart on every new run so an aborted wait leaves no residue
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         count <= 14'h0000;
      end else if (count != 14'(CYCLES - 1)) begin
         count <= count + 14'h0001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done <= 1'b0;
      end else begin
         done <= run && (count == 14'(CYCLES - 2)); // one pulse per wait
      end
   end

endmodule : swcc_delay_timer

// ==== src/swcc_pkg.sv ====
/*
 * types of the sleep and wake-up clock control block.
 * takes no numbers from swcc_defines.svh; state codes and field widths are written here.
 */
package swcc_pkg;

   // one-hot sleep sequencer states
   typedef enum logic [3:0] {
      SWCC_RUN = 4'b0001,
      SWCC_ECO_WAIT = 4'b0010,
      SWCC_SLEEP_ECO = 4'b0100,
      SWCC_SLEEP_NORM = 4'b1000
   } swcc_state_t;

   // clock selection carried to the clock generator
   typedef struct packed {
      logic [1:0] source;
      logic [1:0] divider;
   } swcc_clk_sel_t;

endpackage : swcc_pkg

// ==== src/swcc_sleep_ctrl.sv ====
/*
 * sleep entry and wake-up clock control with an axi4-lite register slave,
 * sticky interrupt flags and a regulator economy mode output.
 * assumes sleep_req and wake_req are one-cycle pulses synchronous to aclk,
 * and a 10 MHz aclk.
 */
`timescale 1ns/100ps
`include "swcc_defines.svh"

module swcc_sleep_ctrl
   import swcc_pkg::*;
#(
   parameter int ECO_DELAY_CYCLES = (`SWCC_ECO_DELAY_NS + `SWCC_CLK_PERIOD_NS - 1) / `SWCC_CLK_PERIOD_NS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sleep_req,
   input wire logic wake_req,
   output logic sleeping,
   output logic economy_mode,
   output swcc_clk_sel_t sysclk_sel,
   output logic [3:0] osc_enable,
   output logic irq
);

   logic [15:0] sclk_reg;
   logic [11:0] osc_reg;
   logic [1:0] flags;
   logic [1:0] irq_mask;
   swcc_state_t state;
   logic aw_held;
   logic w_held;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [31:0] wr_mask;
   logic wr_fire;
   logic wr_mapped;
   logic [31:0] next_rdata;
   logic rd_mapped;
   logic eco_done;
   logic wake_fire;
   logic wake_reload;
   logic [1:0] wake_src;
   logic [3:0] keep_mask;

   // byte lanes expand to a bit mask
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign wr_mask[gi*8 +: 8] = {8{wr_strb[gi]}};
      end
   endgenerate

   // address and data are taken in either order, write happens once both are held
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign wr_mapped = (wr_addr == `SWCC_SCLK_OFS) || (wr_addr == `SWCC_OSC_OFS) ||
                      (wr_addr == `SWCC_FLAG_OFS) || (wr_addr == `SWCC_MASK_OFS) ||
                      (wr_addr == `SWCC_STAT_OFS);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         wr_addr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         wr_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         wr_data <= 32'h0000_0000;
         wr_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         wr_data <= s_axi_wdata;
         wr_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   // write response; unmapped addresses answer slverr
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // wake-up handling is decided from the register contents at the wake edge
   assign wake_fire = wake_req && (state != SWCC_RUN);
   assign wake_reload = sclk_reg[`SWCC_WMODE_POS];
   assign wake_src = sclk_reg[`SWCC_WSRC_POS +: 2];
   assign keep_mask = osc_reg[`SWCC_KEEP_POS +: 4];

   // system clock control; a wake reload wins over a software write in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sclk_reg <= `SWCC_SCLK_RESET;
      end else if (wake_fire && wake_reload) begin
         sclk_reg[`SWCC_SRC_POS +: 2] <= wake_src;
         sclk_reg[`SWCC_DIV_POS +: 2] <= sclk_reg[`SWCC_WDIV_POS +: 2];
      end else if (wr_fire && wr_addr == `SWCC_SCLK_OFS) begin
         sclk_reg <= ((sclk_reg & ~wr_mask[15:0]) | (wr_data[15:0] & wr_mask[15:0])) & `SWCC_SCLK_BITS;
      end
   end

   // oscillator enables; on a wake reload, unused sources are stopped unless kept for sleep
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_reg <= `SWCC_OSC_RESET;
      end else if (wake_fire && wake_reload) begin
         osc_reg[`SWCC_EN_POS +: 4] <= osc_reg[`SWCC_EN_POS +: 4] &
                                       ((4'h1 << wake_src) | keep_mask);
      end else if (wr_fire && wr_addr == `SWCC_OSC_OFS) begin
         osc_reg <= ((osc_reg & ~wr_mask[11:0]) | (wr_data[11:0] & wr_mask[11:0])) & `SWCC_OSC_BITS;
      end
   end

   // sleep sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= SWCC_RUN;
      end else begin
         unique case (state)
            SWCC_RUN: begin
               if (sleep_req) begin
                  if (osc_reg[`SWCC_EN_POS +: 4] == `SWCC_LOW_SPEED_ONLY) begin
                     state <= SWCC_ECO_WAIT;
                  end else begin
                     state <= SWCC_SLEEP_NORM;
                  end
               end
            end
            SWCC_ECO_WAIT: begin
               if (wake_req) begin
                  state <= SWCC_RUN;
               end else if (eco_done) begin
                  state <= SWCC_SLEEP_ECO;
               end
            end
            SWCC_SLEEP_ECO, SWCC_SLEEP_NORM: begin
               if (wake_req) begin
                  state <= SWCC_RUN;
               end
            end
            default: begin
               state <= SWCC_RUN;
            end
         endcase
      end
   end

   swcc_delay_timer #(
      .CYCLES(ECO_DELAY_CYCLES)
   ) u_eco_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(state == SWCC_ECO_WAIT && !wake_req),
      .done(eco_done)
   );

   // sticky flags; a hardware set wins over a write-one clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags <= 2'b00;
      end else begin
         flags <= (flags & ~((wr_fire && wr_addr == `SWCC_FLAG_OFS) ? (wr_data[1:0] & wr_mask[1:0]) : 2'b00))
                  | {wake_fire, eco_done && state == SWCC_ECO_WAIT && !wake_req};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask <= 2'b00;
      end else if (wr_fire && wr_addr == `SWCC_MASK_OFS) begin
         irq_mask <= (irq_mask & ~wr_mask[1:0]) | (wr_data[1:0] & wr_mask[1:0]);
      end
   end

   // outputs to the clock generator come straight from flops; economy_mode for the regulator is decoded from state
   assign sysclk_sel.source = sclk_reg[`SWCC_SRC_POS +: 2];
   assign sysclk_sel.divider = sclk_reg[`SWCC_DIV_POS +: 2];
   assign osc_enable = osc_reg[`SWCC_EN_POS +: 4];
   assign sleeping = (state != SWCC_RUN);
   assign economy_mode = (state == SWCC_SLEEP_ECO);
   assign irq = |(flags & irq_mask);

   // read mux; status holds economy_mode and sleeping, decoded from sequencer state
   always_comb begin
      next_rdata = 32'h0000_0000;
      rd_mapped = 1'b1;
      case (s_axi_araddr)
         `SWCC_SCLK_OFS: next_rdata[15:0] = sclk_reg;
         `SWCC_OSC_OFS: next_rdata[11:0] = osc_reg;
         `SWCC_FLAG_OFS: next_rdata[1:0] = flags;
         `SWCC_MASK_OFS: next_rdata[1:0] = irq_mask;
         `SWCC_STAT_OFS: next_rdata[1:0] = {economy_mode, sleeping};
         default: rd_mapped = 1'b0;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= rd_mapped ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : swcc_sleep_ctrl

// ==== test/swcc_sleep_ctrl_sva.sv ====
/* checker: sleep entry, economy timing and wake-up enable clearing.
   assumes it is bound to swcc_sleep_ctrl and sees only its ports. */
`timescale 1ns/100ps
module swcc_sleep_ctrl_sva
   import swcc_pkg::*;
#(
   parameter int ECO_DELAY_CYCLES = 10000
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic sleep_req,
   input wire logic wake_req,
   input wire logic sleeping,
   input wire logic economy_mode,
   input wire swcc_clk_sel_t sysclk_sel,
   input wire logic [3:0] osc_enable
);
   int cnt;
   logic eco_ok;
   // cycles since sleep entry, and whether only the slow crystal ran then
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 0;
         eco_ok <= 1'b0;
      end else if (sleep_req && !sleeping) begin
         cnt <= 1;
         eco_ok <= (osc_enable == 4'h2);
      end else begin
         cnt <= cnt + 1;
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_eco_delay_win: assert property ($rose(economy_mode) |-> sleeping && cnt >= ECO_DELAY_CYCLES - 1 &&
      cnt <= ECO_DELAY_CYCLES + 1) else $error("economy entered off time");
   a_eco_needs_slow: assert property (economy_mode |-> eco_ok) else $error("economy with fast source");
   a_sleep_entry: assert property (sleep_req && !sleeping |=> sleeping && !economy_mode)
      else $error("sleep not entered");
   a_eco_stays: assert property (economy_mode && !wake_req |=> economy_mode) else $error("economy dropped");
   a_wake_exit: assert property (wake_req && sleeping |=> !sleeping && !economy_mode)
      else $error("wake not taken");
   a_wake_no_new_en: assert property ($fell(sleeping) |->
      (osc_enable & ~$past(osc_enable) & ~(4'h1 << sysclk_sel.source)) == 4'h0 &&
      (~osc_enable & $past(osc_enable) & (4'h1 << sysclk_sel.source)) == 4'h0) else $error("enable wrong at wake");
endmodule : swcc_sleep_ctrl_sva

bind swcc_sleep_ctrl swcc_sleep_ctrl_sva #(.ECO_DELAY_CYCLES(ECO_DELAY_CYCLES)) u_sva (.aclk, .aresetn,
   .sleep_req, .wake_req, .sleeping, .economy_mode, .sysclk_sel, .osc_enable);

// ==== test/testbench.sv ====
/* testbench: register access, sleep and wake sequences, interrupt.
   assumes the checker is bound from its own file; short eco delay. */
`timescale 1ns/100ps
module testbench;
   import swcc_pkg::*;
   localparam int ECO = 20;
   logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic sleep_req = 1'b0, wake_req = 1'b0, awr, wr_, bv, arr, rv, sleeping, economy_mode, irq;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rdat, rd_v;
   logic [1:0] br, br_v, rr, rr_v;
   logic [3:0] osc_enable;
   swcc_clk_sel_t sysclk_sel;
   int fail_count = 0, samples_checked = 0;
   swcc_sleep_ctrl #(.ECO_DELAY_CYCLES(ECO)) u_dut (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
      .sleep_req, .wake_req, .sleeping, .economy_mode, .sysclk_sel, .osc_enable, .irq);
   // 100 ns clock
   initial begin
      forever #50 aclk = ~aclk;
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // ready is looked at on the falling edge, so it matches what the rising edge takes
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit pa, pw, ta, tw;
      pa = 1;
      pw = 1;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      while (pa || pw) begin
         @(negedge aclk);
         ta = pa && awr;
         tw = pw && wr_;
         @(posedge aclk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         pa = pa && !ta;
         pw = pw && !tw;
      end
      do @(negedge aclk); while (!bv);
      br_v = br;
      // bready stays high so back-to-back calls never lower and raise it in one step
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do @(negedge aclk); while (!arr);
      @(posedge aclk);
      arv <= 1'b0;
      do @(negedge aclk); while (!rv);
      rd_v = rdat;
      rr_v = rr;
      @(posedge aclk);
   endtask : rd
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(n, rd_v, e);
   endtask : rchk
   // one-cycle event; returns on the edge that takes it
   task automatic pulse(input bit w);
      if (w) wake_req <= 1'b1;
      else sleep_req <= 1'b1;
      @(posedge aclk);
      wake_req <= 1'b0;
      sleep_req <= 1'b0;
   endtask : pulse
   task automatic nap(input int n);
      pulse(0);
      repeat (n) @(posedge aclk);
      pulse(1);
      @(negedge aclk);
   endtask : nap
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   // watchdog: the whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge aclk);
      fail_count++;
      close_out;
   end
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rchk("sclk", 8'h00, 32'h0);
      rchk("osc", 8'h04, 32'h1);
      $display("reset test done");
      pulse(0);
      repeat (ECO + 4) @(negedge aclk);
      chk("eco fast", economy_mode, 32'h0);
      @(posedge aclk);
      pulse(1);
      wr(8'h08, 32'h3);
      wr(8'h0c, 32'h1);
      wr(8'h04, 32'h2);
      pulse(0);
      repeat (ECO - 2) @(negedge aclk);
      chk("eco early", economy_mode, 32'h0);
      repeat (4) @(negedge aclk);
      chk("eco", economy_mode, 32'h1);
      chk("irq", irq, 32'h1);
      @(posedge aclk);
      rchk("flags", 8'h08, 32'h1);
      rchk("status", 8'h10, 32'h3);
      wr(8'h0c, 32'h0);
      chk("irq masked", irq, 32'h0);
      wr(8'h08, 32'h1);
      wr(8'h0c, 32'h1);
      chk("irq cleared", irq, 32'h0);
      pulse(1);
      $display("economy test done");
      // wake settings differ from the running ones
      wr(8'h04, 32'h40f);
      wr(8'h00, 32'ha110);
      chk("bresp okay", br_v, 32'h0);
      nap(3);
      chk("sel reload", sysclk_sel, 32'h6);
      chk("en clear", osc_enable, 32'h6);
      @(posedge aclk);
      rchk("sclk after", 8'h00, 32'ha121);
      $display("reload test done");
      wr(8'h04, 32'h00f);
      wr(8'h00, 32'h3200);
      nap(3);
      chk("sel kept", sysclk_sel, 32'h0);
      chk("en kept", osc_enable, 32'hf);
      @(posedge aclk);
      $display("no reload test done");
      // a wake inside the economy wait aborts it: no mode flag, only the wake flag
      wr(8'h04, 32'h002);
      wr(8'h08, 32'h3);
      nap(3);
      chk("abort eco", economy_mode, 32'h0);
      repeat (ECO + 2) @(posedge aclk);
      rchk("abort flags", 8'h08, 32'h2);
      $display("abort test done");
      wr(8'h20, 32'h1);
      chk("unmapped bresp", br_v, 32'h2);
      rd(8'h20);
      chk("unmapped resp", rr_v, 32'h2);
      chk("unmapped data", rd_v, 32'h0);
      $display("unmapped test done");
      close_out;
   end
endmodule : testbench
